// [pcint_pkg.sv]
// Purpose: Shared constants and types for the pin change interrupt block.
// Assumes: APB with 32-bit data, registers one aligned word each.
// Notes:   Offsets here are byte addresses.
package pcint_pkg;

    localparam int          DATA_W        = 32;
    localparam int          ADDR_W        = 8;
    localparam int          PORT_W        = 8;

    localparam logic [7:0]  OFS_PA_RISE   = 8'h00;
    localparam logic [7:0]  OFS_PA_FALL   = 8'h04;
    localparam logic [7:0]  OFS_PA_FLAG   = 8'h08;
    localparam logic [7:0]  OFS_PB_RISE   = 8'h0c;
    localparam logic [7:0]  OFS_PB_FALL   = 8'h10;
    localparam logic [7:0]  OFS_PB_FLAG   = 8'h14;
    localparam logic [7:0]  OFS_PC_RISE   = 8'h18;
    localparam logic [7:0]  OFS_PC_FALL   = 8'h1c;
    localparam logic [7:0]  OFS_PC_FLAG   = 8'h20;
    localparam logic [7:0]  OFS_CTRL      = 8'h24;

    // Implemented bit masks per port.
    localparam logic [7:0]  PA_MASK       = 8'h3f;
    localparam logic [7:0]  PB_MASK       = 8'hf0;
    localparam logic [7:0]  PC_MASK       = 8'hff;

    // Control register fields.
    localparam int          CTRL_MEN_BIT  = 0;
    localparam int          CTRL_SUM_BIT  = 1;

    localparam logic [7:0]  RESET_BYTE    = 8'h00;

    typedef struct packed {
        logic [7:0] rise;
        logic [7:0] fall;
        logic [7:0] flag;
        logic [7:0] sync1;
        logic [7:0] sync2;
        logic [7:0] prev;
    } pcint_port_t;

    typedef struct packed {
        pcint_port_t [2:0] port;
        logic              master_en;
        logic              irq;
        logic              wake;
        logic              pready;
        logic              pslverr;
        logic [31:0]       prdata;
    } pcint_state_t;

endpackage : pcint_pkg

// [pcint_top.sv]
// Purpose: Per-pin edge detection with sticky flags for three ports, APB registers.
// Assumes: Pins are synchronised here; sleep control lives outside the block.
// Notes:   Flags are set by hardware and cleared by writing zero; a set wins.
//
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/1ns

// Contract
// - An enabled edge on a pin sets that pin's change flag.
// - Interrupt request is raised only while the master enable is set.
// - Summary flag is the OR of all pin flags and is read-only.
// - Writing zero to a flag bit clears it.
// - An edge during the clearing write keeps the flag set.
// - Enabled edge wakes from sleep only with master enable set.
// - Edges during sleep are already in the flags at wake.
// - Port A rise enables occupy bits 5 to 0.
// - Port A fall enables occupy bits 5 to 0.
// - Port A flag sets on enabled rise or enabled fall.
// - Port B enables and flags exist only in bits 7 to 4.
// - Port B flag sets on enabled rise or enabled fall.
// - Port C rise and fall enables occupy bits 7 to 0.
// - Port C flag sets on enabled rise or enabled fall.
// - A cleared enable bit never sets the flag for that polarity.
// - Unimplemented bits ignore writes and read as zero.
// - All enables and flags reset to zero on every reset.
// - Flags are hardware-settable and software readable and writable.
// - Detection and flagging continue with master enable clear.
// - Both enables set flag edges of either polarity.
module pcint_top (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst,
    input  wire logic [7:0]  i_porta_pin,
    input  wire logic [7:0]  i_portb_pin,
    input  wire logic [7:0]  i_portc_pin,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    input  wire logic [3:0]  i_pstrb,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    output logic             o_irq,
    output logic             o_wake
);

    pcint_pkg::pcint_state_t state_reg;
    pcint_pkg::pcint_state_t state_next;

    function automatic logic [7:0] port_mask(input int idx);
        case (idx)
            0:       port_mask = pcint_pkg::PA_MASK;
            1:       port_mask = pcint_pkg::PB_MASK;
            default: port_mask = pcint_pkg::PC_MASK;
        endcase
    endfunction : port_mask

    // Returns the rise, fall or flag register of the port whose register sits at the address; zero for any other address.
    function automatic logic [7:0] reg_read(input pcint_pkg::pcint_state_t s,
                                            input logic [7:0] addr);
        case (addr)
            pcint_pkg::OFS_PA_RISE: reg_read = s.port[0].rise;
            pcint_pkg::OFS_PA_FALL: reg_read = s.port[0].fall;
            pcint_pkg::OFS_PA_FLAG: reg_read = s.port[0].flag;
            pcint_pkg::OFS_PB_RISE: reg_read = s.port[1].rise;
            pcint_pkg::OFS_PB_FALL: reg_read = s.port[1].fall;
            pcint_pkg::OFS_PB_FLAG: reg_read = s.port[1].flag;
            pcint_pkg::OFS_PC_RISE: reg_read = s.port[2].rise;
            pcint_pkg::OFS_PC_FALL: reg_read = s.port[2].fall;
            pcint_pkg::OFS_PC_FLAG: reg_read = s.port[2].flag;
            default:                reg_read = 8'h00;
        endcase
    endfunction : reg_read

    function automatic logic addr_mapped(input logic [7:0] addr);
        case (addr)
            pcint_pkg::OFS_PA_RISE, pcint_pkg::OFS_PA_FALL, pcint_pkg::OFS_PA_FLAG,
            pcint_pkg::OFS_PB_RISE, pcint_pkg::OFS_PB_FALL, pcint_pkg::OFS_PB_FLAG,
            pcint_pkg::OFS_PC_RISE, pcint_pkg::OFS_PC_FALL, pcint_pkg::OFS_PC_FLAG,
            pcint_pkg::OFS_CTRL:    addr_mapped = 1'b1;
            default:                addr_mapped = 1'b0;
        endcase
    endfunction : addr_mapped

    always_comb begin
        logic [7:0] pins [3];
        logic [7:0] rise_ev;
        logic [7:0] fall_ev;
        logic [7:0] hit;
        logic       wr;
        logic       rd;
        logic       any_hit;
        logic       summary;
        logic [7:0] base;
        pins[0] = '0;
        pins[1] = '0;
        pins[2] = '0;
        rise_ev = '0;
        fall_ev = '0;
        hit = '0;
        base = '0;
        any_hit = 1'b0;
        summary = 1'b0;
        state_next = state_reg;
        pins[0] = i_porta_pin;
        pins[1] = i_portb_pin;
        pins[2] = i_portc_pin;
        // Access phase completes in its second cycle; pready is registered and pulses for one cycle.
        wr = i_psel && i_penable && !state_reg.pready && i_pwrite;
        rd = i_psel && i_penable && !state_reg.pready && !i_pwrite;
        state_next.pready = i_psel && i_penable && !state_reg.pready;
        state_next.pslverr = state_next.pready && !addr_mapped(i_paddr);
        for (int p = 0; p < 3; p++) begin
            // Two-stage synchroniser; only sync2 feeds the comparison.
            state_next.port[p].sync1 = pins[p] & port_mask(p);
            state_next.port[p].sync2 = state_reg.port[p].sync1;
            state_next.port[p].prev = state_reg.port[p].sync2;
            rise_ev = state_reg.port[p].sync2 & ~state_reg.port[p].prev;
            fall_ev = ~state_reg.port[p].sync2 & state_reg.port[p].prev;
            // Either polarity may flag when both enables are set.
            hit = ((rise_ev & state_reg.port[p].rise) |
                   (fall_ev & state_reg.port[p].fall)) & port_mask(p);
            any_hit = any_hit | (|hit);
            base = state_reg.port[p].flag;
            case (p)
                0: base = (wr && i_paddr == pcint_pkg::OFS_PA_FLAG && i_pstrb[0]) ?
                          i_pwdata[7:0] : base;
                1: base = (wr && i_paddr == pcint_pkg::OFS_PB_FLAG && i_pstrb[0]) ?
                          i_pwdata[7:0] : base;
                default: base = (wr && i_paddr == pcint_pkg::OFS_PC_FLAG && i_pstrb[0]) ?
                          i_pwdata[7:0] : base;
            endcase
            // A new edge overrides a clearing write in the same cycle.
            state_next.port[p].flag = (base | hit) & port_mask(p);
        end
        if (wr && i_pstrb[0]) begin
            unique case (i_paddr)
                pcint_pkg::OFS_PA_RISE: state_next.port[0].rise = i_pwdata[7:0] & pcint_pkg::PA_MASK;
                pcint_pkg::OFS_PA_FALL: state_next.port[0].fall = i_pwdata[7:0] & pcint_pkg::PA_MASK;
                pcint_pkg::OFS_PB_RISE: state_next.port[1].rise = i_pwdata[7:0] & pcint_pkg::PB_MASK;
                pcint_pkg::OFS_PB_FALL: state_next.port[1].fall = i_pwdata[7:0] & pcint_pkg::PB_MASK;
                pcint_pkg::OFS_PC_RISE: state_next.port[2].rise = i_pwdata[7:0] & pcint_pkg::PC_MASK;
                pcint_pkg::OFS_PC_FALL: state_next.port[2].fall = i_pwdata[7:0] & pcint_pkg::PC_MASK;
                pcint_pkg::OFS_CTRL:    state_next.master_en = i_pwdata[pcint_pkg::CTRL_MEN_BIT];
                default:                ;
            endcase
        end
        summary = (|state_next.port[0].flag) | (|state_next.port[1].flag) |
                  (|state_next.port[2].flag);
        // Flags keep updating with the master enable clear; only the request and wake are gated.
        state_next.irq = summary && state_next.master_en;
        // Flags are written in the same edge as wake rises, so they lead the first fetch.
        state_next.wake = any_hit && state_next.master_en;
        state_next.prdata = '0;
        if (rd) begin
            if (i_paddr == pcint_pkg::OFS_CTRL) begin
                state_next.prdata[pcint_pkg::CTRL_MEN_BIT] = state_reg.master_en;
                state_next.prdata[pcint_pkg::CTRL_SUM_BIT] = |{state_reg.port[0].flag,
                    state_reg.port[1].flag, state_reg.port[2].flag};
            end else begin
                state_next.prdata[7:0] = reg_read(state_reg, i_paddr);
            end
        end
        if (i_rst) begin
            state_next = '0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        state_reg <= state_next;
    end

    assign o_prdata  = state_reg.prdata;
    assign o_pready  = state_reg.pready;
    assign o_pslverr = state_reg.pslverr;
    assign o_irq     = state_reg.irq;
    assign o_wake    = state_reg.wake;

endmodule : pcint_top

// [pcint_pins.sv]
// Purpose: Model of the external port pins feeding the block.
// Assumes: Pin levels change only just after a rising clock edge.
// Notes:   Pins are driven push-pull, so they never float.
`timescale 1ns/1ns
module pcint_pins (
    input  wire logic [23:0] i_level,
    input  wire logic        i_clk_sys,
    output logic      [23:0] o_pins
);
    always @(posedge i_clk_sys) begin
        o_pins <= i_level;
    end
endmodule : pcint_pins

// [pcint_checker.sv]
// Purpose: Port-level checks for the pin change interrupt block.
// Assumes: One clock domain with a synchronous active-high reset.
// Notes:   Bound to every instance of the top module.
`timescale 1ns/1ns
module pcint_checker (
    input wire logic        i_clk_sys,
    input wire logic        i_rst,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    input wire logic        o_irq,
    input wire logic        o_wake
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    AST_PREADY_ONE: assert property (o_pready |=> !o_pready)
        else $error("pready held longer than one cycle");
    AST_PREADY_ANSWER: assert property (i_psel && i_penable && !o_pready |=> o_pready)
        else $error("access not answered in time");
    AST_PREADY_CAUSE: assert property (o_pready |-> $past(i_psel && i_penable))
        else $error("pready without an access");
    AST_ERR_ZERO: assert property (o_pslverr |-> o_pready && o_prdata == 32'h0)
        else $error("error response malformed");
    AST_IDLE_DATA: assert property (!o_pready |-> o_prdata == 32'h0)
        else $error("read data outside answer");
    AST_UPPER_ZERO: assert property (o_pready |-> o_prdata[31:8] == 24'h0)
        else $error("unimplemented bits read nonzero");
    AST_RESET_QUIET: assert property ($past(i_rst) |-> !o_irq && !o_wake && !o_pready)
        else $error("outputs active after reset");
    AST_WAKE_IRQ: assert property (o_wake |-> o_irq)
        else $error("wake without interrupt request");
    AST_IRQ_STICKY: assert property ($fell(o_irq) |-> $past(i_psel && i_pwrite))
        else $error("request dropped without a write");
    cover property (o_wake);
    cover property (o_pslverr);
    cover property ($fell(o_irq));
endmodule : pcint_checker
bind pcint_top pcint_checker chk (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .o_irq(o_irq), .o_wake(o_wake));

// [pcint_bench.sv]
// Purpose: Self-checking bench for the pin change interrupt block.
// Assumes: Pins come from the pin model, registers over APB.
// Notes:   Flags are cleared by read-modify-write so unseen edges survive.
`timescale 1ns/1ns
module pcint_bench;
    logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [3:0]  strb = 4'h1;
    logic [31:0] wdata = 32'h0, prdata, rdata;
    logic [23:0] lvl = 24'h0, pins;
    logic        pready, pslverr, irq, wake, err;
    int          fail_count = 0, cmp_count = 0, cyc = 0, nwake;
    always #50 clk = ~clk;
    pcint_pins model (.i_level(lvl), .i_clk_sys(clk), .o_pins(pins));
    pcint_top dut (.i_clk_sys(clk), .i_rst(rst), .i_porta_pin(pins[7:0]),
        .i_portb_pin(pins[15:8]), .i_portc_pin(pins[23:16]), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wdata), .i_pstrb(strb), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .o_irq(irq), .o_wake(wake));
    task automatic summarize();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwr <= w;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check($sformatf("reg %h", a), rdata, exp);
    endtask : rd
    task automatic clr(input logic [7:0] a, input logic [7:0] seen);
        apb(1'b0, a, 32'h0);
        apb(1'b1, a, rdata & ~{24'h0, seen});
    endtask : clr
    task automatic wt(input int n);
        nwake = 0;
        repeat (n) begin
            @(posedge clk);
            if (wake === 1'b1) nwake++;
        end
    endtask : wt
    task automatic t_reset();
        for (int i = 0; i < 10; i++) rd(8'(i * 4), 32'h0);
        apb(1'b0, 8'h28, 32'h0);
        check("unmapped error", {31'h0, err}, 32'h1);
    endtask : t_reset
    task automatic t_regs();
        for (int i = 0; i < 9; i++) begin
            apb(1'b1, 8'(i * 4), 32'hffffffff);
            rd(8'(i * 4), {24'h0, i < 3 ? 8'h3f : i < 6 ? 8'hf0 : 8'hff});
        end
        rd(8'h24, 32'h2);
        apb(1'b1, 8'h24, 32'h1);
        check("irq on", {31'h0, irq}, 32'h1);
        for (int i = 2; i < 9; i += 3) apb(1'b1, 8'(i * 4), 32'h0);
        check("irq off", {31'h0, irq}, 32'h0);
        apb(1'b1, 8'h24, 32'h3);
        rd(8'h24, 32'h1);
        for (int i = 0; i < 10; i++) apb(1'b1, 8'(i * 4), 32'h0);
    endtask : t_regs
    task automatic t_edges();
        apb(1'b1, 8'h00, 32'h01);
        apb(1'b1, 8'h04, 32'h02);
        apb(1'b1, 8'h0c, 32'h10);
        apb(1'b1, 8'h18, 32'h80);
        apb(1'b1, 8'h1c, 32'h80);
        lvl <= 24'h801003;
        wt(6);
        check("wake masked", nwake, 0);
        check("irq masked", {31'h0, irq}, 32'h0);
        rd(8'h08, 32'h01);
        rd(8'h14, 32'h10);
        rd(8'h20, 32'h80);
        clr(8'h08, 8'h01);
        clr(8'h14, 8'h10);
        clr(8'h20, 8'h80);
        lvl <= 24'h0;
        wt(6);
        rd(8'h08, 32'h02);
        rd(8'h14, 32'h0);
        rd(8'h20, 32'h80);
        apb(1'b1, 8'h24, 32'h1);
        lvl <= 24'h000001;
        wt(6);
        check("wake count", nwake, 1);
        rd(8'h08, 32'h03);
    endtask : t_edges
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            fail_count++;
            summarize();
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_regs();
        t_edges();
        summarize();
    end
endmodule : pcint_bench
